// File: hdl/cpp_channel_port.sv
// Channel parallel port: CPU-style FIFO, pin toggling, activity LEDs, flush/wake
// What this block does
// - Select high ignores strobes; address picks data/status
// - Status: rx avail, tx space, suspend, configured
// - CPU FIFO mode only from EEPROM configuration
// - Async mode drives update/sample strobes onto pins
// - Async mode self-clocks bytes at baud rate
// - Async outputs change on new data and tick
// - Direction mask from mode command, held
// - Mode value 1 async, 4 sync
// - Sync mode updates pins per received byte
// - Sync samples pins before applying byte
// - Sync proceeds only with room in the two-entry upstream buffer
// - Sync sequence: read, send, drive, setup, strobe
// - Serial mode drives two activity LEDs low
// - One-shot timer stretches LED activity
// - Flush/wake input honoured in FIFO, pin modes
// - Falling edge flushes upstream short packet
// - Pull-down enabled blocks leaving suspend
`timescale 1ns/1ps
`include "cpp_regs.svh"
module cpp_channel_port #(
    parameter int DATA_W = 8,
    parameter int LED_CYCLES = `CPP_LED_CYCLES
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Configuration and USB state
    input wire logic eeprom_cpu_fifo,
    input wire logic usb_suspended,
    input wire logic usb_configured,
    input wire logic wake_pulldown_en,
    input wire logic baud_tick,
    // Mode command from host
    input wire logic mode_cmd_valid,
    input wire logic [7:0] mode_cmd_value,
    input wire logic [DATA_W-1:0] mode_cmd_mask,
    // USB receive FIFO (host to pins)
    input wire logic rx_valid,
    input wire logic [DATA_W-1:0] rx_data,
    output logic rx_ready,
    // USB transmit FIFO (pins to host)
    output logic tx_valid,
    output logic [DATA_W-1:0] tx_data,
    input wire logic tx_ready,
    // Host side events
    output logic flush_req,
    output logic wake_req,
    // CPU-style port pins
    input wire logic port_sel_n,
    input wire logic port_addr_bit,
    input wire logic port_rd_n,
    input wire logic port_wr_n,
    input wire logic [DATA_W-1:0] port_data_in,
    output logic [DATA_W-1:0] port_data_out,
    output logic port_data_oe,
    // Pin-toggling pins
    input wire logic [DATA_W-1:0] pins_in,
    output logic [DATA_W-1:0] pins_out,
    output logic [DATA_W-1:0] pins_oe,
    output logic pin_update_strobe_n,
    output logic pin_sample_strobe_n,
    // Activity LEDs, open drain
    output logic led_tx_out,
    output logic led_tx_oe,
    output logic led_rx_out,
    output logic led_rx_oe,
    // Flush / wake input
    input wire logic flush_wake_n
);
    function automatic logic cpu_access(input logic sel_n, input logic addr, input logic a);
        cpu_access = !sel_n && (addr == a);
    endfunction : cpu_access

    localparam int LW = $clog2(LED_CYCLES + 1);

    cpp_pkg::cpp_port_e port_mode;
    cpp_pkg::cpp_sync_e sy_state;
    logic pins_async;
    logic [DATA_W-1:0] async_hold;
    logic async_pending;
    logic [DATA_W-1:0] sample;
    logic [DATA_W-1:0] sync_byte;
    logic rd_q, wr_q, fw_q;
    logic [1:0] buf_cnt;
    logic [DATA_W-1:0] buf_d0, buf_d1;
    logic buf_in_valid, buf_in_ready;
    logic [DATA_W-1:0] buf_in_data;
    logic [LW-1:0] led_tx_cnt, led_rx_cnt;
    logic rx_take, fw_fall, rd_fall, wr_fall, honour;

    // Mode selection; CPU FIFO only comes from the EEPROM strap
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_mode <= cpp_pkg::CPP_PORT_UART;
            pins_async <= 1'b0;
            pins_oe <= '0;
        end else if (clk_en) begin
            if (eeprom_cpu_fifo) begin
                port_mode <= cpp_pkg::CPP_PORT_CPU_FIFO;
            end else if (mode_cmd_valid) begin
                pins_oe <= mode_cmd_mask;
                if (mode_cmd_value == `CPP_MODE_ASYNC) begin
                    port_mode <= cpp_pkg::CPP_PORT_PINS;
                    pins_async <= 1'b1;
                end else if (mode_cmd_value == `CPP_MODE_SYNC) begin
                    port_mode <= cpp_pkg::CPP_PORT_PINS;
                    pins_async <= 1'b0;
                end else begin
                    port_mode <= cpp_pkg::CPP_PORT_UART;
                end
            end else if (port_mode == cpp_pkg::CPP_PORT_CPU_FIFO) begin
                // Strap gone: stop decoding the CPU pins instead of keeping a stale mode
                port_mode <= cpp_pkg::CPP_PORT_UART;
            end
        end
    end

    // Edge detection of strobes and flush/wake input
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            fw_q <= 1'b1;
        end else if (clk_en) begin
            rd_q <= port_rd_n;
            wr_q <= port_wr_n;
            fw_q <= flush_wake_n;
        end
    end
    assign rd_fall = rd_q && !port_rd_n;
    assign wr_fall = wr_q && !port_wr_n;
    assign fw_fall = fw_q && !flush_wake_n;

    wire cpu_mode = (port_mode == cpp_pkg::CPP_PORT_CPU_FIFO);
    wire pin_mode = (port_mode == cpp_pkg::CPP_PORT_PINS);
    wire sync_mode = pin_mode && !pins_async;
    wire cpu_rd_data = cpu_mode && rd_fall && cpu_access(port_sel_n, port_addr_bit, `CPP_ADDR_DATA);
    wire cpu_wr_data = cpu_mode && wr_fall && cpu_access(port_sel_n, port_addr_bit, `CPP_ADDR_DATA);
    wire cpu_wr_flush = cpu_mode && wr_fall
        && cpu_access(port_sel_n, port_addr_bit, `CPP_ADDR_STATUS);

    // CPU port read side: data or status, select high ignores the strobes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            port_data_out <= '0;
        end else if (clk_en && cpu_mode && rd_fall) begin
            if (cpu_access(port_sel_n, port_addr_bit, `CPP_ADDR_STATUS)) begin
                port_data_out <= DATA_W'({`CPP_ST_HIGH_VALUE, usb_configured, usb_suspended,
                    tx_ready, rx_valid});
            end else if (cpu_rd_data) begin
                port_data_out <= rx_data;
            end
        end
    end
    assign port_data_oe = cpu_mode && !port_sel_n && !port_rd_n;

    // Receive FIFO consumption per mode
    assign rx_take = rx_valid && rx_ready;
    always_comb begin
        rx_ready = 1'b0;
        if (cpu_mode) begin
            rx_ready = cpu_rd_data;
        end else if (pin_mode && pins_async) begin
            rx_ready = !async_pending;
        end else if (sync_mode) begin
            rx_ready = (sy_state == cpp_pkg::CPP_SY_IDLE) && buf_in_ready;
        end
    end

    // Async pins: hold last value until new data meets a baud tick
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            async_hold <= '0;
            async_pending <= 1'b0;
        end else if (clk_en && pin_mode && pins_async) begin
            if (async_pending && baud_tick) begin
                async_pending <= 1'b0;
            end else if (rx_take) begin
                async_hold <= rx_data;
                async_pending <= 1'b1;
            end
        end
    end

    // Sync cycle sequencer and pin/strobe drive
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sy_state <= cpp_pkg::CPP_SY_IDLE;
            sample <= '0;
            pins_out <= '0;
            pin_update_strobe_n <= 1'b1;
            pin_sample_strobe_n <= 1'b0;
        end else if (clk_en) begin
            if (pin_mode && pins_async) begin
                pin_sample_strobe_n <= !(rx_take);
                pin_update_strobe_n <= !(async_pending && baud_tick);
                if (async_pending && baud_tick) begin
                    pins_out <= async_hold;
                end
            end else begin
                case (sy_state)
                    cpp_pkg::CPP_SY_IDLE: begin
                        if (sync_mode && rx_take) begin
                            sample <= pins_in;
                            sy_state <= cpp_pkg::CPP_SY_SEND;
                        end
                    end
                    cpp_pkg::CPP_SY_SEND: begin
                        pin_sample_strobe_n <= 1'b1;
                        sy_state <= cpp_pkg::CPP_SY_DRIVE;
                    end
                    cpp_pkg::CPP_SY_DRIVE: begin
                        pin_sample_strobe_n <= 1'b0;
                        pins_out <= sync_byte;
                        sy_state <= cpp_pkg::CPP_SY_SETUP;
                    end
                    cpp_pkg::CPP_SY_SETUP: begin
                        pin_update_strobe_n <= 1'b0;
                        sy_state <= cpp_pkg::CPP_SY_STROBE;
                    end
                    cpp_pkg::CPP_SY_STROBE: begin
                        pin_update_strobe_n <= 1'b1;
                        sy_state <= cpp_pkg::CPP_SY_IDLE;
                    end
                    default: sy_state <= cpp_pkg::CPP_SY_IDLE;
                endcase
            end
        end
    end

    // Byte taken from the receive FIFO, held for the drive step
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync_byte <= '0;
        end else if (clk_en && sync_mode && rx_take) begin
            sync_byte <= rx_data;
        end
    end

    // Upstream words: CPU writes, sync samples during the send step
    always_comb begin
        buf_in_valid = 1'b0;
        buf_in_data = port_data_in;
        if (cpu_wr_data) begin
            buf_in_valid = 1'b1;
        end else if (sync_mode && sy_state == cpp_pkg::CPP_SY_SEND) begin
            buf_in_valid = 1'b1;
            buf_in_data = sample;
        end
    end

    // Two-entry buffer toward the transmit FIFO; a CPU write while it is full is dropped
    assign buf_in_ready = (buf_cnt != 2'd2);
    assign tx_valid = (buf_cnt != 2'd0);
    assign tx_data = buf_d0;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            buf_cnt <= 2'd0;
            buf_d0 <= '0;
            buf_d1 <= '0;
        end else if (clk_en) begin
            case ({buf_in_valid && buf_in_ready, tx_valid && tx_ready})
                2'b10: begin
                    if (buf_cnt == 2'd0) buf_d0 <= buf_in_data;
                    else buf_d1 <= buf_in_data;
                    buf_cnt <= buf_cnt + 2'd1;
                end
                2'b01: begin
                    buf_d0 <= buf_d1;
                    buf_cnt <= buf_cnt - 2'd1;
                end
                2'b11: begin
                    if (buf_cnt == 2'd1) buf_d0 <= buf_in_data;
                    else begin
                        buf_d0 <= buf_d1;
                        buf_d1 <= buf_in_data;
                    end
                end
                default: buf_cnt <= buf_cnt;
            endcase
        end
    end

    // Flush and wake; pull-down keeps the channel asleep
    assign honour = cpu_mode || pin_mode;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flush_req <= 1'b0;
            wake_req <= 1'b0;
        end else if (clk_en) begin
            flush_req <= cpu_wr_flush
                || (honour && fw_fall && !usb_suspended);
            wake_req <= honour && fw_fall && usb_suspended
                && !wake_pulldown_en;
        end
    end

    // Activity LEDs in serial mode, stretched so short bursts stay visible
    wire uart_mode = (port_mode == cpp_pkg::CPP_PORT_UART);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            led_tx_cnt <= '0;
            led_rx_cnt <= '0;
        end else if (clk_en) begin
            if (uart_mode && tx_valid && tx_ready) led_tx_cnt <= LW'(LED_CYCLES);
            else if (led_tx_cnt != '0) led_tx_cnt <= led_tx_cnt - 1'b1;
            if (uart_mode && rx_take) led_rx_cnt <= LW'(LED_CYCLES);
            else if (led_rx_cnt != '0) led_rx_cnt <= led_rx_cnt - 1'b1;
        end
    end
    assign led_tx_out = 1'b0;
    assign led_rx_out = 1'b0;
    assign led_tx_oe = uart_mode && (led_tx_cnt != '0);
    assign led_rx_oe = uart_mode && (led_rx_cnt != '0);
endmodule : cpp_channel_port

// File: hdl/cpp_pkg.sv
// Types for the channel parallel port block
package cpp_pkg;
    typedef enum logic [1:0] {
        CPP_PORT_UART,
        CPP_PORT_CPU_FIFO,
        CPP_PORT_PINS
    } cpp_port_e;
    typedef enum logic [2:0] {
        CPP_SY_IDLE,
        CPP_SY_SEND,
        CPP_SY_DRIVE,
        CPP_SY_SETUP,
        CPP_SY_STROBE
    } cpp_sync_e;
endpackage : cpp_pkg

// File: hdl/cpp_regs.svh
// Constants for the channel parallel port block
`ifndef CPP_REGS_SVH
`define CPP_REGS_SVH
`define CPP_ADDR_DATA 1'h0
`define CPP_ADDR_STATUS 1'h1
`define CPP_ST_RXAVAIL 0
`define CPP_ST_TXSPACE 1
`define CPP_ST_SUSPEND 2
`define CPP_ST_CONFIG 3
`define CPP_ST_HIGH_VALUE 4'h0
`define CPP_MODE_RESET 8'h00
`define CPP_MODE_ASYNC 8'h01
`define CPP_MODE_SYNC 8'h04
`define CPP_LED_TIME_MS 50
`define CPP_CLK_HZ 20000000
`define CPP_LED_CYCLES ((`CPP_LED_TIME_MS * `CPP_CLK_HZ) / 1000)
`endif

// File: test/cpp_channel_port_assertions.sv
// Concurrent checks on the channel parallel port pins
`timescale 1ns/1ps
module cpp_channel_port_chk #(
    parameter int DATA_W = 8,
    parameter int LED_CYCLES = 4
) (
    // Watched ports, grouped tightly to keep the checker short
    input wire logic ref_clk, rst, clk_en, eeprom_cpu_fifo, usb_suspended, usb_configured,
    input wire logic wake_pulldown_en, mode_cmd_valid, rx_valid, tx_ready, flush_req, wake_req,
    input wire logic port_sel_n, port_addr_bit, port_rd_n, port_wr_n, port_data_oe,
    input wire logic pin_update_strobe_n, flush_wake_n,
    input wire logic [7:0] mode_cmd_value,
    input wire logic [DATA_W-1:0] mode_cmd_mask, port_data_out, pins_out, pins_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_sel_off; port_sel_n |-> !port_data_oe; endproperty
    a_sel_off: assert property (p_sel_off) else $error("data bus driven while deselected");
    property p_status; $fell(port_rd_n) && !port_sel_n && port_addr_bit && eeprom_cpu_fifo
        && clk_en |=> port_data_out[3:0] ==
        $past({usb_configured, usb_suspended, tx_ready, rx_valid}); endproperty
    a_status: assert property (p_status) else $error("status nibble wrong");
    property p_send_imm; $fell(port_wr_n) && !port_sel_n && port_addr_bit && eeprom_cpu_fifo
        && clk_en |=> flush_req; endproperty
    a_send_imm: assert property (p_send_imm) else $error("status write gave no flush");
    property p_mask; mode_cmd_valid && clk_en && !eeprom_cpu_fifo && (mode_cmd_value == 8'h01
        || mode_cmd_value == 8'h04) |=> pins_oe == $past(mode_cmd_mask); endproperty
    a_mask: assert property (p_mask) else $error("direction mask not applied");
    // Mode switches may legally move the pins, so those cycles are left out
    property p_pins; $changed(pins_out) && !$past(mode_cmd_valid) && !$past(mode_cmd_valid, 2)
        |-> ##[0:1] !pin_update_strobe_n; endproperty
    a_pins: assert property (p_pins) else $error("pins moved without update strobe");
    property p_upd_pulse; $fell(pin_update_strobe_n) |=> pin_update_strobe_n; endproperty
    a_upd_pulse: assert property (p_upd_pulse) else $error("update strobe too long");
    property p_flush; $fell(flush_wake_n) && eeprom_cpu_fifo && !usb_suspended && clk_en
        |=> flush_req; endproperty
    a_flush: assert property (p_flush) else $error("falling edge gave no flush");
    property p_wake; $fell(flush_wake_n) && eeprom_cpu_fifo && usb_suspended
        && !wake_pulldown_en && clk_en |=> wake_req; endproperty
    a_wake: assert property (p_wake) else $error("falling edge gave no wake");
    property p_pulldown; $past(wake_pulldown_en) |-> !wake_req; endproperty
    a_pulldown: assert property (p_pulldown) else $error("wake with pull-down on");
endmodule : cpp_channel_port_chk
bind cpp_channel_port cpp_channel_port_chk #(.DATA_W(DATA_W), .LED_CYCLES(LED_CYCLES)) i_chk (
    .ref_clk, .rst, .clk_en, .eeprom_cpu_fifo, .usb_suspended, .usb_configured,
    .wake_pulldown_en, .mode_cmd_valid, .rx_valid, .tx_ready, .flush_req, .wake_req,
    .port_sel_n, .port_addr_bit, .port_rd_n, .port_wr_n, .port_data_oe,
    .pin_update_strobe_n, .flush_wake_n, .mode_cmd_value, .mode_cmd_mask,
    .port_data_out, .pins_out, .pins_oe);

// File: test/cpp_channel_port_bench.sv
// Bench for the channel parallel port block
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("ERROR %0t: got %0h want %0h", $time, a, e); end end
module cpp_channel_port_bench;
    logic ref_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, eeprom_cpu_fifo = 1'b0;
    logic usb_suspended = 1'b0, usb_configured = 1'b0, wake_pulldown_en = 1'b0;
    logic baud_tick = 1'b0, mode_cmd_valid = 1'b0, rx_valid = 1'b0, tx_ready = 1'b0;
    logic port_sel_n = 1'b1, port_addr_bit = 1'b0, port_rd_n = 1'b1, port_wr_n = 1'b1;
    logic [7:0] mode_cmd_value = 8'h00, mode_cmd_mask = 8'h00, rx_data = 8'h00;
    logic [7:0] port_data_in = 8'hC3, ext_level = 8'hA0;
    logic rx_ready, tx_valid, flush_req, wake_req, port_data_oe, flush_wake_n;
    logic pin_update_strobe_n, pin_sample_strobe_n, led_tx_oe, led_rx_oe, samp_q = 1'b0;
    logic [7:0] tx_data, port_data_out, pins_in, pins_out, pins_oe;
    int mismatches = 0, compares = 0, cyc = 0, takes = 0, flushes = 0, wakes = 0;
    int upds = 0, oes = 0, sfalls = 0;
    // Status inputs {configured, suspended, tx room, rx data} beside the expected nibble
    logic [7:0] rows [4] = '{8'h11, 8'h22, 8'h44, 8'h88};
    cpp_channel_port #(.LED_CYCLES(4)) i_dut (.ref_clk, .rst, .clk_en, .eeprom_cpu_fifo,
        .usb_suspended, .usb_configured, .wake_pulldown_en, .baud_tick, .mode_cmd_valid,
        .mode_cmd_value, .mode_cmd_mask, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data,
        .tx_ready, .flush_req, .wake_req, .port_sel_n, .port_addr_bit, .port_rd_n, .port_wr_n,
        .port_data_in, .port_data_out, .port_data_oe, .pins_in, .pins_out, .pins_oe,
        .pin_update_strobe_n, .pin_sample_strobe_n, .led_tx_out(), .led_tx_oe(led_tx_oe),
        .led_rx_out(), .led_rx_oe(led_rx_oe), .flush_wake_n);
    cpp_far_logic i_far (.ref_clk, .pins_out, .pins_oe, .ext_level, .pins_in, .flush_wake_n);
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    // Event counters sampled mid-cycle, away from the edges that move them
    always @(negedge ref_clk) begin
        cyc++;
        flushes += flush_req;
        wakes += wake_req;
        upds += !pin_update_strobe_n;
        oes += port_data_oe;
        sfalls += samp_q && !pin_sample_strobe_n;
        samp_q = pin_sample_strobe_n;
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    // With the EEPROM strap off, a taken byte drops valid at the same edge so it is not resent
    always @(posedge ref_clk) begin
        if (rx_valid && rx_ready && !eeprom_cpu_fifo) begin
            takes++;
            rx_valid <= 1'b0;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick
    task automatic set_mode(input logic [7:0] v, input logic [7:0] m);
        @(posedge ref_clk);
        mode_cmd_valid <= 1'b1;
        mode_cmd_value <= v;
        mode_cmd_mask <= m;
        @(posedge ref_clk);
        mode_cmd_valid <= 1'b0;
        tick(2);
    endtask : set_mode
    task automatic wait_takes(input int t);
        for (int i = 0; i < 100 && takes < t; i++) @(negedge ref_clk);
        `CHK(takes, t)
    endtask : wait_takes
    task automatic send(input logic [7:0] b);
        int n;
        n = takes;
        @(posedge ref_clk);
        rx_data <= b;
        rx_valid <= 1'b1;
        wait_takes(n + 1);
    endtask : send
    task automatic get_word(input logic [7:0] e);
        @(posedge ref_clk);
        tx_ready <= 1'b1;
        for (int i = 0; i < 100 && tx_valid !== 1'b1; i++) @(negedge ref_clk);
        `CHK({tx_valid, tx_data}, {1'b1, e})
        @(posedge ref_clk);
        tx_ready <= 1'b0;
    endtask : get_word
    // Strobes stay apart by at least two cycles
    task automatic cpu(input logic wr, input logic a);
        @(posedge ref_clk);
        port_sel_n <= 1'b0;
        port_addr_bit <= a;
        @(posedge ref_clk);
        if (wr)
            port_wr_n <= 1'b0;
        else
            port_rd_n <= 1'b0;
        tick(2);
        port_rd_n <= 1'b1;
        port_wr_n <= 1'b1;
        port_sel_n <= 1'b1;
        tick(1);
    endtask : cpu
    initial begin
        int n;
        tick(16);
        rst <= 1'b0;
        tick(2);
        cpu(1'b0, 1'b1);
        `CHK(oes, 0)
        eeprom_cpu_fifo <= 1'b1;
        cpu(1'b1, 1'b0);
        get_word(8'hC3);
        rx_data <= 8'h5A;
        rx_valid <= 1'b1;
        cpu(1'b0, 1'b0);
        `CHK(port_data_out, 8'h5A)
        foreach (rows[i]) begin
            {usb_configured, usb_suspended, tx_ready, rx_valid} <= rows[i][7:4];
            cpu(1'b0, 1'b1);
            `CHK(port_data_out[3:0], rows[i][3:0])
        end
        {usb_configured, usb_suspended, tx_ready, rx_valid} <= 4'h0;
        cpu(1'b1, 1'b1);
        `CHK(flushes, 1)
        `CHK({led_tx_oe, led_rx_oe}, 2'b00)
        n = oes;
        port_rd_n <= 1'b0;
        tick(4);
        port_rd_n <= 1'b1;
        `CHK(oes, n)
        i_far.pulse(5);
        tick(3);
        `CHK(flushes, 2)
        usb_suspended <= 1'b1;
        i_far.pulse(5);
        tick(3);
        `CHK(wakes, 1)
        wake_pulldown_en <= 1'b1;
        i_far.pulse(5);
        tick(3);
        `CHK(wakes, 1)
        usb_suspended <= 1'b0;
        wake_pulldown_en <= 1'b0;
        eeprom_cpu_fifo <= 1'b0;
        i_far.pulse(5);
        tick(3);
        `CHK(flushes, 2)
        // Synchronous mode with a stalled upstream: a full buffer must hold off the third byte
        set_mode(8'h04, 8'h0F);
        `CHK(pins_oe, 8'h0F)
        send(8'h55);
        send(8'hAA);
        @(posedge ref_clk);
        rx_data <= 8'h3C;
        rx_valid <= 1'b1;
        tick(20);
        `CHK(takes, 2)
        get_word(8'hA0);
        wait_takes(3);
        get_word(8'hA5);
        get_word(8'hAA);
        `CHK(pins_out, 8'h3C)
        `CHK(upds, 3)
        set_mode(8'h01, 8'hFF);
        send(8'h96);
        tick(10);
        `CHK(pins_out, 8'h3C)
        baud_tick <= 1'b1;
        @(posedge ref_clk);
        baud_tick <= 1'b0;
        tick(2);
        `CHK(pins_out, 8'h96)
        `CHK(upds, 4)
        `CHK(sfalls, 4)
        finish_test();
    end
endmodule : cpp_channel_port_bench

// File: test/cpp_far_logic.sv
// External logic on the pin bus and the flush/wake line
`timescale 1ns/1ps
module cpp_far_logic (
    input wire logic ref_clk,
    input wire logic [7:0] pins_out,
    input wire logic [7:0] pins_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pins_in,
    output logic flush_wake_n
);
    // Output pins read back what the block drives, inputs see the far side level
    assign pins_in = (pins_out & pins_oe) | (ext_level & ~pins_oe);
    initial flush_wake_n = 1'b1;
    // Low pulse of n cycles; only called once writes have stopped
    task automatic pulse(input int n);
        @(posedge ref_clk);
        flush_wake_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        flush_wake_n <= 1'b1;
    endtask : pulse
endmodule : cpp_far_logic
